/* mpc_map.vh */
// constants and register map for the maintenance panel control block
`ifndef MPC_MAP_VH
`define MPC_MAP_VH
`define MPC_OFF_CTRL      12'h000
`define MPC_OFF_SWITCH    12'h004
`define MPC_OFF_ACTION    12'h008
`define MPC_OFF_STATUS    12'h00C
`define MPC_OFF_DISPLAY   12'h010
`define MPC_OFF_CMPR      12'h014
`define MPC_OFF_CMD0      12'h018
`define MPC_OFF_CMD1      12'h01C
`define MPC_OFF_CMD2      12'h020
`define MPC_OFF_CMD3      12'h024
`define MPC_OFF_BYTECNT   12'h028
`define MPC_OFF_WRDATA    12'h02C
`define MPC_OFF_GODOWN    12'h030
`define MPC_OFF_CHECKS    12'h034
`define MPC_OFF_SEQ       12'h038
// control register fields
`define MPC_CTRL_DISP_LSB 0
`define MPC_CTRL_ENTRY_LSB 3
`define MPC_CTRL_ALU2     6
`define MPC_CTRL_MPLE     7
`define MPC_CTRL_WRDATA   8
// action register bits (write one pulses)
`define MPC_ACT_SETCMP    0
`define MPC_ACT_START     1
`define MPC_ACT_STOP      2
`define MPC_ACT_CLRCHK    3
// display selector codes
`define MPC_DISP_CEREG    3'h0
`define MPC_DISP_CMPR     3'h1
`define MPC_DISP_IC       3'h2
`define MPC_DISP_BUSIN    3'h3
`define MPC_DISP_BUSOUT   3'h4
`define MPC_DISP_HIROS    3'h5
`define MPC_DISP_LOROS    3'h6
// data entry selector codes
`define MPC_ENT_CMPR      3'h0
`define MPC_ENT_CMD1      3'h1
`define MPC_ENT_BYTECNT   3'h5
`define MPC_ENT_WRDATA    3'h6
// byte count, go-down and command gap figures
`define MPC_BC_MULT       16'h0400
`define MPC_BC_PAD        16'h0003
`define MPC_BC_SHORT      16'h0002
`define MPC_GD_BASE_US    6000
`define MPC_GD_STEP_US    26000
`define MPC_CLK_MHZ       100
`define MPC_CMD_GAP       8'h10
`endif

/* mpc_panel.v */
// maintenance panel control: entry registers, command sequencer, indicators and checks
// Functional notes
// - set-compare loads entry switches into selected register, regardless of enable/offline.
// - offline command controls ignored unless interfaces offline.
// - multiple mode loops the four stored commands continuously.
// - single mode advances one command per start press.
// - start begins command execution; stop ends continuous cycling.
// - compare display shows compare register on indicators 0-11.
// - counter display shows selected ALU's instruction counter.
// - inbound display: ALU1 channel data/tags, ALU2 tape data/address.
// - outbound display: data on 0-7, controls/tags on 8-11.
// - upper store display: bits 0-7 plus parity; ALU1 adds control lines 9-11. Parity is not shown here; indicator 8 stays dark.
// - lower store display: bits 8-15 plus parity; ALU1 adds control lines 9-11. Parity is not shown here; indicator 8 stays dark.
// - four command slots, each command plus device address 0-F.
// - byte count is left/centre value plus right switch times 1024.
// - dialled 00-FE writes count plus three; FF writes two.
// - write pattern from left (high) and centre switches with auto parity.
// - go-down delay 6.0 ms plus 26 ms per right-switch step.
// - command code from left and centre switches, unit address from right switch.
// - compare-equal lit when compare register matches selected register.
// - branch-condition error when even number of condition groups active.
// - ALU-to-external transfers check storage register output for odd parity.
// - upper check set by counter, store, multi-decode or branch errors.
// - lower counter checked on branches; lower store every cycle.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mpc_map.vh"
module mpc_panel #(
  parameter CMD_W  = 8,
  parameter GD_TICKS_PER_STEP = `MPC_GD_STEP_US * `MPC_CLK_MHZ,
  parameter GD_TICKS_BASE     = `MPC_GD_BASE_US * `MPC_CLK_MHZ
) (
  input  wire        pclk,
  input  wire        presetn,
  // apb register bus
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // operator panel offline switch, not on this clock
  input  wire        intf_offline_in,
  // alu state shown on the indicators
  input  wire [11:0] alu1_counter,
  input  wire [11:0] alu2_counter,
  input  wire [7:0]  chan_in_data,
  input  wire [3:0]  chan_in_tags,
  input  wire [7:0]  tape_in_data,
  input  wire [3:0]  tape_dev_addr,
  input  wire [7:0]  chan_out_data,
  input  wire [3:0]  chan_out_ctl,
  input  wire [7:0]  tape_out_data,
  input  wire [3:0]  tape_out_ctl,
  input  wire [17:0] alu1_store_word,
  input  wire [17:0] alu2_store_word,
  input  wire [2:0]  alu1_ctl_lines,
  // check inputs, sampled on this clock
  input  wire [15:0] branch_groups,
  input  wire        upper_counter_perr,
  input  wire        upper_store_perr,
  input  wire        multi_decode,
  input  wire        lower_counter_perr,
  input  wire        lower_store_perr,
  input  wire        cycle_done,
  input  wire        unconditional_branch,
  input  wire        conditional_branch_taken,
  input  wire        alu_to_ext,
  input  wire [8:0]  local_storage_register,
  // panel indicators and offline command outputs
  output reg  [11:0] indicators,
  output wire        intf_offline_lamp,
  output reg         compare_equal,
  output reg         cmd_issue,
  output reg  [CMD_W-1:0] cmd_code,
  output reg  [3:0]  cmd_unit,
  output reg  [15:0] byte_count,
  output reg  [8:0]  write_pattern,
  output reg  [31:0] godown_ticks,
  // latched check indicators
  output wire        upper_check,
  output wire        lower_check,
  output wire        branch_error,
  output wire        bbus_error,
  output wire        hw_error
);
  localparam SQ_IDLE = 2'h0;
  localparam SQ_RUN  = 2'h1;
  localparam SQ_WAIT = 2'h2;

  reg  [11:0] sw_q;
  reg  [8:0]  ctrl_q;
  reg  [11:0] cmpr_q;
  reg  [11:0] slot_q [0:3];
  reg  [11:0] bytecnt_sw_q;
  reg  [11:0] wrdata_sw_q;
  reg  [1:0]  sq_state_q;
  reg  [1:0]  slot_idx_q;
  reg  [7:0]  gap_q;
  wire        upper_chk_q;
  wire        lower_chk_q;
  wire        branch_chk_q;
  wire        bbus_chk_q;
  wire        off_s2_q;
  reg  [11:0] rd_sel;
  integer     i;

  wire [2:0]  disp_sel  = ctrl_q[`MPC_CTRL_DISP_LSB +: 3];
  wire [2:0]  entry_sel = ctrl_q[`MPC_CTRL_ENTRY_LSB +: 3];
  wire        alu2      = ctrl_q[`MPC_CTRL_ALU2];
  wire        mple      = ctrl_q[`MPC_CTRL_MPLE];
  wire        wr_mode   = ctrl_q[`MPC_CTRL_WRDATA];
  wire        wr_act    = psel & penable & pwrite;
  wire        act_hit   = wr_act & (paddr == `MPC_OFF_ACTION);
  wire        sw_hit    = wr_act & (paddr == `MPC_OFF_SWITCH);
  wire        ctrl_hit  = wr_act & (paddr == `MPC_OFF_CTRL);
  wire        offline   = off_s2_q;
  wire        set_cmp   = act_hit & pwdata[`MPC_ACT_SETCMP];
  wire        start_p   = act_hit & pwdata[`MPC_ACT_START] & offline;
  wire        stop_p    = act_hit & pwdata[`MPC_ACT_STOP] & offline;
  wire        clr_chk   = act_hit & pwdata[`MPC_ACT_CLRCHK];
  wire [1:0]  slot_sel  = entry_sel[1:0] - 2'h1;

  // zero wait states; every access ends in one cycle
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign intf_offline_lamp = offline;

  // offline level comes from the panel switch, so synchronise it
  mpc_sync2 i_mpc_sync2_offline (
    .pclk    (pclk),
    .presetn (presetn),
    .async_in(intf_offline_in),
    .sync_q  (off_s2_q)
  );

  // switch, selector and entry registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q         <= 12'h000;
      ctrl_q       <= 9'h000;
      cmpr_q       <= 12'h000;
      bytecnt_sw_q <= 12'h000;
      wrdata_sw_q  <= 12'h000;
      for (i = 0; i < 4; i = i + 1)
        slot_q[i] <= 12'h000;
    end else begin
      if (sw_hit)
        sw_q <= pwdata[11:0];
      if (ctrl_hit)
        ctrl_q <= pwdata[8:0];
      // set-compare needs neither panel enable nor offline
      if (set_cmp) begin
        case (entry_sel)
          `MPC_ENT_CMPR:    cmpr_q <= sw_q;
          `MPC_ENT_BYTECNT: bytecnt_sw_q <= sw_q;
          `MPC_ENT_WRDATA:  wrdata_sw_q <= sw_q;
          3'h1, 3'h2, 3'h3, 3'h4: slot_q[slot_sel] <= sw_q;
          default: cmpr_q <= cmpr_q;
        endcase
      end
    end
  end

  // dialled count, kilobyte multiplier and the short case
  wire [15:0] bc_dialled = {8'h00, bytecnt_sw_q[11:4]};
  wire [15:0] bc_kilo    = `MPC_BC_MULT * {12'h000, bytecnt_sw_q[3:0]};
  wire        bc_short   = (bytecnt_sw_q[11:4] == 8'hFF);

  // derived byte count, pattern and go-down delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_count    <= 16'h0000;
      write_pattern <= 9'h000;
      godown_ticks  <= 32'h00000000;
    end else begin
      if (bc_short)
        byte_count <= `MPC_BC_SHORT + bc_kilo;
      else
        byte_count <= bc_dialled + `MPC_BC_PAD + bc_kilo;
      // parity bit keeps the byte odd; left switch is the high nibble
      // ripple mode leaves the last pattern in place
      if (wr_mode)
        write_pattern <= {~^wrdata_sw_q[11:4], wrdata_sw_q[11:4]};
      // counted in ticks so a short bench can shrink both parameters
      godown_ticks  <= GD_TICKS_BASE + GD_TICKS_PER_STEP * {28'h0000000, wrdata_sw_q[3:0]};
    end
  end

  // offline command sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq_state_q <= SQ_IDLE;
      slot_idx_q <= 2'h0;
      gap_q      <= 8'h00;
      cmd_issue  <= 1'b0;
      cmd_code   <= {CMD_W{1'b0}};
      cmd_unit   <= 4'h0;
    end else begin
      cmd_issue <= 1'b0;
      if (!offline) begin
        // going online drops any run in progress
        sq_state_q <= SQ_IDLE;
      end else begin
        case (sq_state_q)
          SQ_IDLE: if (start_p) sq_state_q <= SQ_RUN;
          SQ_RUN: begin
            cmd_issue  <= 1'b1;
            cmd_code   <= slot_q[slot_idx_q][11:4];
            cmd_unit   <= slot_q[slot_idx_q][3:0];
            slot_idx_q <= slot_idx_q + 2'h1;
            // gap gives the far side time to take each command
            gap_q      <= `MPC_CMD_GAP;
            // a stop landing on the issue cycle still ends the loop
            sq_state_q <= (mple && !stop_p) ? SQ_WAIT : SQ_IDLE;
          end
          SQ_WAIT: begin
            // stop only breaks a continuous run
            if (stop_p)
              sq_state_q <= SQ_IDLE;
            else if (gap_q == 8'h00)
              sq_state_q <= SQ_RUN;
            else
              gap_q <= gap_q - 8'h01;
          end
          default: sq_state_q <= SQ_IDLE;
        endcase
      end
    end
  end

  // indicator routing
  // indicator 0 is the most significant bit
  always @* begin
    case (disp_sel)
      `MPC_DISP_CMPR:   rd_sel = cmpr_q;
      `MPC_DISP_IC:     rd_sel = alu2 ? alu2_counter : alu1_counter;
      `MPC_DISP_BUSIN:  rd_sel = alu2 ? {tape_in_data, tape_dev_addr} : {chan_in_data, chan_in_tags};
      `MPC_DISP_BUSOUT: rd_sel = alu2 ? {tape_out_data, tape_out_ctl} : {chan_out_data, chan_out_ctl};
      // indicator 8 stays dark on the store displays
      `MPC_DISP_HIROS:  rd_sel = alu2 ? {alu2_store_word[17:10], 4'h0}
                                      : {alu1_store_word[17:10], 1'b0, alu1_ctl_lines};
      `MPC_DISP_LOROS:  rd_sel = alu2 ? {alu2_store_word[8:1], 4'h0}
                                      : {alu1_store_word[8:1], 1'b0, alu1_ctl_lines};
      `MPC_DISP_CEREG: begin
        case (entry_sel)
          `MPC_ENT_BYTECNT: rd_sel = bytecnt_sw_q;
          `MPC_ENT_WRDATA:  rd_sel = wrdata_sw_q;
          3'h1, 3'h2, 3'h3, 3'h4: rd_sel = slot_q[slot_sel];
          default: rd_sel = cmpr_q;
        endcase
      end
      default: rd_sel = 12'h000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicators    <= 12'h000;
      compare_equal <= 1'b0;
    end else begin
      // compare follows the displayed register
      indicators    <= rd_sel;
      compare_equal <= (cmpr_q == rd_sel);
    end
  end

  // latched checks; a new error beats a clear in the same cycle
  wire br_err  = ~^branch_groups;
  wire bb_err  = alu_to_ext & ~^local_storage_register;
  wire up_err  = upper_counter_perr | upper_store_perr | multi_decode | br_err;
  wire lo_err  = cycle_done & (lower_store_perr |
                 ((unconditional_branch | conditional_branch_taken) & lower_counter_perr));
  mpc_sticky i_mpc_sticky_upper (
    .pclk    (pclk),
    .presetn (presetn),
    .set_in  (up_err),
    .clr_in  (clr_chk),
    .flag_q  (upper_chk_q)
  );

  mpc_sticky i_mpc_sticky_lower (
    .pclk    (pclk),
    .presetn (presetn),
    .set_in  (lo_err),
    .clr_in  (clr_chk),
    .flag_q  (lower_chk_q)
  );

  mpc_sticky i_mpc_sticky_branch (
    .pclk    (pclk),
    .presetn (presetn),
    .set_in  (br_err),
    .clr_in  (clr_chk),
    .flag_q  (branch_chk_q)
  );

  mpc_sticky i_mpc_sticky_bbus (
    .pclk    (pclk),
    .presetn (presetn),
    .set_in  (bb_err),
    .clr_in  (clr_chk),
    .flag_q  (bbus_chk_q)
  );
  assign upper_check  = upper_chk_q;
  assign lower_check  = lower_chk_q;
  assign branch_error = branch_chk_q;
  assign bbus_error   = bbus_chk_q;
  assign hw_error     = upper_chk_q | lower_chk_q | bbus_chk_q;

  // apb read mux
  always @* begin
    case (paddr)
      `MPC_OFF_CTRL:    prdata = {23'h000000, ctrl_q};
      `MPC_OFF_SWITCH:  prdata = {20'h00000, sw_q};
      `MPC_OFF_STATUS:  prdata = {29'h00000000, compare_equal, cmd_issue, offline};
      `MPC_OFF_DISPLAY: prdata = {20'h00000, indicators};
      `MPC_OFF_CMPR:    prdata = {20'h00000, cmpr_q};
      // slot words read back as loaded, code high and unit low
      `MPC_OFF_CMD0:    prdata = {20'h00000, slot_q[0]};
      `MPC_OFF_CMD1:    prdata = {20'h00000, slot_q[1]};
      `MPC_OFF_CMD2:    prdata = {20'h00000, slot_q[2]};
      `MPC_OFF_CMD3:    prdata = {20'h00000, slot_q[3]};
      `MPC_OFF_BYTECNT: prdata = {16'h0000, byte_count};
      `MPC_OFF_WRDATA:  prdata = {23'h000000, write_pattern};
      `MPC_OFF_GODOWN:  prdata = godown_ticks;
      `MPC_OFF_CHECKS:  prdata = {28'h0000000, bbus_chk_q, branch_chk_q, lower_chk_q, upper_chk_q};
      `MPC_OFF_SEQ:     prdata = {28'h0000000, slot_idx_q, sq_state_q};
      default:          prdata = 32'h00000000;
    endcase
  end
endmodule

// sticky check latch; a new error wins over a clear in the same cycle
module mpc_sticky (
  input  wire pclk,
  input  wire presetn,
  input  wire set_in,
  input  wire clr_in,
  output reg  flag_q
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= set_in | (flag_q & ~clr_in);
    end
  end
endmodule

// two-flop synchroniser; only the second stage leaves this module
module mpc_sync2 (
  input  wire pclk,
  input  wire presetn,
  input  wire async_in,
  output reg  sync_q
);
  reg meta_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* mpc_panel_assertions.sv */
// checker: error latching, offline gating and command issue of the panel
`timescale 1ns/1ps
`default_nettype none
`include "mpc_map.vh"
module mpc_panel_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        intf_offline_in,
  input wire logic [15:0] branch_groups,
  input wire logic        upper_counter_perr,
  input wire logic        multi_decode,
  input wire logic        lower_store_perr,
  input wire logic        cycle_done,
  input wire logic        alu_to_ext,
  input wire logic [8:0]  local_storage_register,
  input wire logic        intf_offline_lamp,
  input wire logic        cmd_issue,
  input wire logic        upper_check,
  input wire logic        lower_check,
  input wire logic        branch_error,
  input wire logic        bbus_error,
  input wire logic        hw_error
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire clr = psel && penable && pwrite && paddr == `MPC_OFF_ACTION && pwdata[`MPC_ACT_CLRCHK];
  sequence s_even_groups; cycle_done && !(^branch_groups); endsequence
  sequence s_quiet_clear; clr && !cycle_done; endsequence
  property p_branch; s_even_groups |-> ##[1:2] (branch_error && upper_check); endproperty
  a_branch: assert property (p_branch) else $error("branch error not flagged");
  property p_upper; cycle_done && (upper_counter_perr || multi_decode) |-> ##[1:2] upper_check; endproperty
  a_upper: assert property (p_upper) else $error("upper check not set");
  property p_lower; cycle_done && lower_store_perr |-> ##[1:2] (lower_check && hw_error); endproperty
  a_lower: assert property (p_lower) else $error("lower check not set");
  property p_bbus; alu_to_ext && !(^local_storage_register) |-> ##[1:2] (bbus_error && hw_error); endproperty
  a_bbus: assert property (p_bbus) else $error("bus parity error not set");
  property p_hold; lower_check && !clr |=> lower_check; endproperty
  a_hold: assert property (p_hold) else $error("check indicator dropped");
  property p_clear; s_quiet_clear |=> !lower_check; endproperty
  a_clear: assert property (p_clear) else $error("check indicator not cleared");
  property p_lamp; $rose(intf_offline_in) |-> ##[1:3] intf_offline_lamp; endproperty
  a_lamp: assert property (p_lamp) else $error("offline lamp late");
  property p_offline; cmd_issue |-> intf_offline_lamp; endproperty
  a_offline: assert property (p_offline) else $error("command issued while online");
  property p_pulse; cmd_issue |=> !cmd_issue; endproperty
  a_pulse: assert property (p_pulse) else $error("command issue longer than one cycle");
endmodule
bind mpc_panel mpc_panel_chk u_chk (.*);
`default_nettype wire

/* mpc_alu_pair.sv */
// partner model: the two ALUs and the buses the panel displays
`timescale 1ns/1ps
`default_nettype none
module mpc_alu_pair (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        cycle_done,
  output var  logic [11:0] alu1_counter,
  output var  logic [11:0] alu2_counter,
  output wire logic [7:0]  chan_in_data,
  output wire logic [3:0]  chan_in_tags,
  output wire logic [7:0]  tape_in_data,
  output wire logic [3:0]  tape_dev_addr,
  output wire logic [7:0]  chan_out_data,
  output wire logic [3:0]  chan_out_ctl,
  output wire logic [7:0]  tape_out_data,
  output wire logic [3:0]  tape_out_ctl,
  output wire logic [17:0] alu1_store_word,
  output wire logic [17:0] alu2_store_word,
  output wire logic [2:0]  alu1_ctl_lines
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alu1_counter <= 12'h3A5;
      alu2_counter <= 12'h5C2;
    end else if (cycle_done) begin
      alu1_counter <= alu1_counter + 12'h001;
      alu2_counter <= alu2_counter + 12'h003;
    end
  end
  // every bus distinct so a wrong display leg shows up
  assign {chan_in_tags, chan_in_data} = ~alu1_counter;
  assign {tape_dev_addr, tape_in_data} = alu2_counter ^ 12'h0F0;
  assign {chan_out_ctl, chan_out_data} = alu1_counter ^ 12'h3C3;
  assign {tape_out_ctl, tape_out_data} = ~alu2_counter;
  assign alu1_store_word = {alu1_counter[5:0], ~alu1_counter};
  assign alu2_store_word = {alu2_counter, alu2_counter[11:6]};
  assign alu1_ctl_lines = alu1_counter[2:0] ^ 3'h5;
endmodule
`default_nettype wire

/* tb.sv */
// testbench: panel entry, displays, command sequencing and checks
`timescale 1ns/1ps
`default_nettype none
`include "mpc_map.vh"
module tb;
  logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000, last_cmd;
  logic [31:0]      pwdata = 32'h0, rd;
  logic             intf_offline_in = 1'b0, cycle_done = 1'b0;
  logic [7:0]       ev = 8'h00;
  logic [15:0]      branch_groups = 16'h0001;
  logic [8:0]       local_storage_register = 9'h001;
  wire logic        upper_counter_perr, upper_store_perr, multi_decode, lower_counter_perr;
  wire logic        lower_store_perr, unconditional_branch, conditional_branch_taken, alu_to_ext;
  wire logic [31:0] prdata, godown_ticks;
  wire logic        pready, pslverr, intf_offline_lamp, compare_equal, cmd_issue;
  wire logic        upper_check, lower_check, branch_error, bbus_error, hw_error;
  wire logic [11:0] alu1_counter, alu2_counter, indicators;
  wire logic [7:0]  chan_in_data, tape_in_data, chan_out_data, tape_out_data, cmd_code;
  wire logic [3:0]  chan_in_tags, tape_dev_addr, chan_out_ctl, tape_out_ctl, cmd_unit;
  wire logic [17:0] alu1_store_word, alu2_store_word;
  wire logic [2:0]  alu1_ctl_lines;
  wire logic [15:0] byte_count;
  wire logic [8:0]  write_pattern;
  int               fail_count = 0, num_checks = 0, issued = 0, b;
  logic [11:0]      rc [11], re [11];
  logic [21:0]      ck [10];
  assign {upper_counter_perr, upper_store_perr, multi_decode, lower_counter_perr, lower_store_perr,
          unconditional_branch, conditional_branch_taken, alu_to_ext} = ev;
  // go-down counts shrunk to 6 and 26 ticks
  mpc_panel #(.GD_TICKS_PER_STEP(26), .GD_TICKS_BASE(6)) i_mpc_panel (.*);
  mpc_alu_pair i_mpc_alu_pair (.*);
  always #5 pclk = ~pclk;
  always @(negedge pclk) begin
    if (cmd_issue === 1'b1) begin
      issued++;
      last_cmd = {cmd_code, cmd_unit};
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      r = prdata;
      rdy = pready;
      @(posedge pclk);
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd);
  endtask
  task automatic ent(input logic [8:0] c, input logic [11:0] sw);
    wr(`MPC_OFF_CTRL, {23'h0, c});
    wr(`MPC_OFF_SWITCH, {20'h0, sw});
    wr(`MPC_OFF_ACTION, 32'h1);
    repeat (2) @(posedge pclk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    ent(9'h000, 12'h5A3);
    rc = '{12'h001, 12'h002, 12'h042, 12'h003, 12'h043, 12'h004, 12'h044, 12'h005, 12'h045, 12'h006, 12'h046};
    re = '{12'h5A3, alu1_counter, alu2_counter, {chan_in_data, chan_in_tags}, {tape_in_data, tape_dev_addr},
           {chan_out_data, chan_out_ctl}, {tape_out_data, tape_out_ctl},
           {alu1_store_word[17:10], 1'b0, alu1_ctl_lines}, {alu2_store_word[17:10], 4'h0},
           {alu1_store_word[8:1], 1'b0, alu1_ctl_lines}, {alu2_store_word[8:1], 4'h0}};
    for (int i = 0; i < 11; i++) begin
      wr(`MPC_OFF_CTRL, {20'h0, rc[i]});
      repeat (2) @(posedge pclk);
      chk("indicators", re[i], indicators);
    end
    ent(9'h000, alu1_counter);
    wr(`MPC_OFF_CTRL, 32'h2);
    repeat (2) @(posedge pclk);
    chk("compare_equal", 1, compare_equal);
    wr(`MPC_OFF_CTRL, 32'h42);
    repeat (2) @(posedge pclk);
    chk("compare_equal", 0, compare_equal);
    apb(1'b0, `MPC_OFF_CMPR, 32'h0, rd);
    chk("prdata cmpr", {20'h0, alu1_counter}, rd);
    chk("pslverr", 0, pslverr);
    ent(9'h028, 12'h443);
    chk("byte_count", 16'h0C47, byte_count);
    ent(9'h028, 12'hFE0);
    chk("byte_count", 16'h0101, byte_count);
    ent(9'h028, 12'hFF0);
    chk("byte_count", 16'h0002, byte_count);
    ent(9'h130, 12'h833);
    chk("write_pattern", 9'h083, write_pattern);
    chk("godown_ticks", 32'h54, godown_ticks);
    ent(9'h130, 12'h810);
    chk("write_pattern", 9'h181, write_pattern);
    chk("godown_ticks", 32'h6, godown_ticks);
    ent(9'h030, 12'h550);
    chk("pattern held", 9'h181, write_pattern);
    for (int k = 1; k < 5; k++) ent({3'h0, 3'(k), 3'h0}, {4'h0, 4'(k), 4'(k + 8)});
    b = issued;
    wr(`MPC_OFF_ACTION, 32'h2);
    repeat (30) @(posedge pclk);
    chk("issued online", b, issued);
    intf_offline_in <= 1'b1;
    repeat (4) @(posedge pclk);
    for (int k = 1; k < 5; k++) begin
      b = issued;
      wr(`MPC_OFF_ACTION, 32'h2);
      repeat (30) @(posedge pclk);
      chk("issued single", b + 1, issued);
      chk("command", {4'h0, 4'(k), 4'(k + 8)}, last_cmd);
    end
    b = issued;
    wr(`MPC_OFF_CTRL, 32'h80);
    wr(`MPC_OFF_ACTION, 32'h2);
    repeat (80) @(posedge pclk);
    chk("looping", 1, issued - b >= 4);
    wr(`MPC_OFF_ACTION, 32'h4);
    repeat (20) @(posedge pclk);
    b = issued;
    repeat (60) @(posedge pclk);
    chk("stopped", b, issued);
    // hand-written awkward cases: error latches
    ck = '{{8'h80, 1'b0, 9'h001, 4'h8}, {8'h40, 1'b0, 9'h001, 4'h8}, {8'h20, 1'b0, 9'h001, 4'h8},
           {8'h00, 1'b1, 9'h001, 4'hA}, {8'h10, 1'b0, 9'h001, 4'h0}, {8'h14, 1'b0, 9'h001, 4'h4},
           {8'h12, 1'b0, 9'h001, 4'h4}, {8'h08, 1'b0, 9'h001, 4'h4}, {8'h01, 1'b0, 9'h003, 4'h1},
           {8'h01, 1'b0, 9'h007, 4'h0}};
    for (int i = 0; i < 10; i++) begin
      ev <= ck[i][21:14];
      branch_groups <= {14'h0, ck[i][13], 1'b1};
      local_storage_register <= ck[i][12:4];
      cycle_done <= 1'b1;
      @(posedge pclk);
      ev <= 8'h00;
      branch_groups <= 16'h0001;
      cycle_done <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("checks", ck[i][3:0], {upper_check, lower_check, branch_error, bbus_error});
      if (ck[i][2] | ck[i][0]) chk("hw_error", 1, hw_error);
      wr(`MPC_OFF_ACTION, 32'h8);
      repeat (2) @(posedge pclk);
      chk("cleared", 0, {upper_check, lower_check, branch_error, bbus_error});
    end
    ev <= 8'h08;
    cycle_done <= 1'b1;
    @(posedge pclk);
    ev <= 8'h00;
    cycle_done <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset", 0, {lower_check, indicators, cmd_issue});
    presetn <= 1'b1;
    apb(1'b0, 12'h3FC, 32'h0, rd);
    chk("unmapped", 0, rd);
    stop_test;
  end
endmodule
`default_nettype wire
